// >>> tcmo_params.svh
// offsets, field positions, reset values and widths of the capture and match output block
`ifndef TCMO_PARAMS_SVH
`define TCMO_PARAMS_SVH

// register byte offsets
`define TCMO_ADDR_W          8
`define TCMO_OFF_CAP_CTRL    8'h80
`define TCMO_OFF_CAP_VALUE   8'h84
`define TCMO_OFF_OUT_STATE   8'h88
`define TCMO_OFF_IRQ_STATUS  8'ha0
`define TCMO_OFF_IRQ_MASK    8'ha4

// capture_control fields
`define TCMO_CTRL_W          4
`define TCMO_BIT_CAP_RISE    0
`define TCMO_BIT_CAP_FALL    1
`define TCMO_BIT_CAP_IRQ     2
`define TCMO_BIT_CAP_EN      3

// interrupt status and mask fields
`define TCMO_NUM_IRQ         2
`define TCMO_IRQ_CAPTURE     0
`define TCMO_IRQ_MATCH       1

// widths and reset values
`define TCMO_COUNT_W         16
`define TCMO_NUM_OUT         24
`define TCMO_RST_CAP_CTRL    4'h0
`define TCMO_RST_CAP_VALUE   16'h0000
`define TCMO_RST_OUT_BIT     1'b0
`define TCMO_RST_IRQ_BIT     1'b0
`define TCMO_RST_SYNC_BIT    1'b0

`endif

// >>> tcmo_pkg.sv
// types shared by the capture and match output block
package tcmo_pkg;

  // per-output action taken when a match value equals the timer count
  typedef enum logic [1:0] {
    TCMO_ACT_NONE   = 2'b00,
    TCMO_ACT_LOW    = 2'b01,
    TCMO_ACT_HIGH   = 2'b10,
    TCMO_ACT_TOGGLE = 2'b11
  } tcmo_action_t;

  function automatic logic tcmo_apply(input tcmo_action_t act, input logic cur);
    logic nxt;
    nxt = cur;
    unique case (act)
      TCMO_ACT_NONE:   nxt = cur;
      TCMO_ACT_LOW:    nxt = 1'b0;
      TCMO_ACT_HIGH:   nxt = 1'b1;
      TCMO_ACT_TOGGLE: nxt = ~cur;
    endcase
    return nxt;
  endfunction

endpackage

// >>> tcmo_edge_sync.sv
// two-flop synchroniser for the capture pin with rise and fall detection
`timescale 1ns/1ps
`include "tcmo_params.svh"
module tcmo_edge_sync
  import tcmo_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // asynchronous pin
  input  wire logic pin_i,
  // one-cycle edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcmo_sync_state_t;

  tcmo_sync_state_t s_q;
  tcmo_sync_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= {3{`TCMO_RST_SYNC_BIT}};
    end else begin
      s_q <= s_d;
    end
  end

  // only the second and third stages are compared, so one transition gives one pulse
  assign rise_o = s_q.sync & ~s_q.prev;   // [R14]
  assign fall_o = ~s_q.sync & s_q.prev;   // [R14]

endmodule

// >>> tcmo_irq_ctrl.sv
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`include "tcmo_params.svh"
module tcmo_irq_ctrl
  import tcmo_pkg::*;
#(
  parameter int NEV = `TCMO_NUM_IRQ
)(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // events from the block
  input  wire logic [NEV-1:0] event_i,
  // software access
  input  wire logic           wr_status_i,
  input  wire logic           wr_mask_i,
  input  wire logic [NEV-1:0] wdata_i,
  // state
  output logic      [NEV-1:0] status_o,
  output logic      [NEV-1:0] mask_o,
  output logic                irq_o
);

  typedef struct packed {
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic           irq;
  } tcmo_irq_state_t;

  tcmo_irq_state_t s_q;
  tcmo_irq_state_t s_d;

  always_comb begin
    s_d = s_q;
    // write one to clear; an event in the same cycle wins over the clear
    if (wr_status_i) begin
      s_d.status = s_q.status & ~wdata_i;
    end
    s_d.status = s_d.status | event_i;
    if (wr_mask_i) begin
      s_d.mask = wdata_i;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= {(2 * NEV + 1){`TCMO_RST_IRQ_BIT}};
    end else begin
      s_q <= s_d;
    end
  end

  assign status_o = s_q.status;
  assign mask_o   = s_q.mask;
  assign irq_o    = s_q.irq;

endmodule

// >>> tcmo_top.sv
// capture register and external match output logic of a 16-bit counter/timer
//
// How it works
// [R1] enable bit 3 arms capture, switches pin
// [R2] irq enable bit 2 flags each capture load
// [R3] falling-select bit 1 captures on high-to-low
// [R4] rising-select bit 0 captures on low-to-high
// [R5] both selects set capture every edge
// [R6] software clears low bits in counter mode
// [R7] capture value 16-bit, read-only, resets zero
// [R8] output follows state bit outside a match
// [R9] pwm mode hands output to pwm logic
// [R10] state register 24 r/w bits, upper zero
// [R11] only the capture pin loads capture value
// [R12] action 01 low, 10 high, 11 toggle
// [R13] every match value compared with count continuously
// [R14] pin synchronised, edges from consecutive samples
// [R15] match action updates state bit, level holds
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "tcmo_params.svh"
module tcmo_top
  import tcmo_pkg::*;
#(
  parameter int NUM_OUT = `TCMO_NUM_OUT,
  parameter int COUNT_W = `TCMO_COUNT_W
)(
  // clock and reset
  input  wire logic                       CLOCK_I,
  input  wire logic                       RST_I,
  // register port
  input  wire logic [`TCMO_ADDR_W-1:0]    ADDR_I,
  input  wire logic [31:0]                WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [31:0]                RDATA_O,
  // timer core
  input  wire logic [COUNT_W-1:0]         TIMER_COUNT_I,
  input  wire logic [NUM_OUT*COUNT_W-1:0] MATCH_VALUE_I,
  input  wire logic [2*NUM_OUT-1:0]       OUTPUT_ACTION_SELECT_I,
  input  wire logic [NUM_OUT-1:0]         PWM_MODE_I,
  input  wire logic [NUM_OUT-1:0]         PWM_LEVEL_I,
  // pins
  input  wire logic                       CAPTURE_INPUT_PIN_I,
  output logic                            CAPTURE_PIN_SELECT_O,
  output logic      [NUM_OUT-1:0]         MATCH_OUTPUT_PIN_O,
  // interrupt
  output logic                            IRQ_O
);

  generate
    if (NUM_OUT < 1 || NUM_OUT > 32 || COUNT_W < 1 || COUNT_W > 32) begin : g_bad_param
      $error("tcmo_top: NUM_OUT and COUNT_W must lie in 1..32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [`TCMO_CTRL_W-1:0] ctrl;
    logic [COUNT_W-1:0]      captured_count;
    logic [NUM_OUT-1:0]      state_bits;
    logic [NUM_OUT-1:0]      hit;
    logic [NUM_OUT-1:0]      pin_out;
    logic                    pin_select;
    logic [31:0]             rdata;
  } tcmo_top_state_t;

  tcmo_top_state_t s_q;
  tcmo_top_state_t s_d;

  logic                     rise;
  logic                     fall;
  logic                     capture_load;
  logic [NUM_OUT-1:0]       match_eq;
  logic [NUM_OUT-1:0]       match_start;
  logic [NUM_OUT-1:0]       action_level;
  logic [`TCMO_NUM_IRQ-1:0] irq_event;
  logic [`TCMO_NUM_IRQ-1:0] irq_status;
  logic [`TCMO_NUM_IRQ-1:0] irq_mask;
  logic                     irq;
  logic                     wr_status;
  logic                     wr_mask;

  ////////////////////////////////////////////////////////////////////////////
  // capture path

  // the sync chain runs even while capture is off, so arming it mid-level
  // does not fake an edge
  tcmo_edge_sync u_edge_sync (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .pin_i  (CAPTURE_INPUT_PIN_I),   // [R11]
    .rise_o (rise),
    .fall_o (fall)
  );

  // both selects together are legal and capture on either edge
  assign capture_load = s_q.ctrl[`TCMO_BIT_CAP_EN]                           // [R1]
                      & ((rise & s_q.ctrl[`TCMO_BIT_CAP_RISE])               // [R4] [R5]
                      |  (fall & s_q.ctrl[`TCMO_BIT_CAP_FALL]));             // [R3] [R5]

  ////////////////////////////////////////////////////////////////////////////
  // match outputs

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      tcmo_action_t act;
      assign act          = tcmo_action_t'(OUTPUT_ACTION_SELECT_I[2*gi +: 2]);
      assign match_eq[gi] = (MATCH_VALUE_I[gi*COUNT_W +: COUNT_W] == TIMER_COUNT_I); // [R13]
      // act once per match, on its first cycle, so a slow count does not
      // toggle the output on every clock it sits on the match value
      assign match_start[gi] = match_eq[gi] & ~s_q.hit[gi]
                             & (act != TCMO_ACT_NONE) & ~PWM_MODE_I[gi];            // [R9] [R15]
      assign action_level[gi] = tcmo_apply(act, s_q.state_bits[gi]);                 // [R12]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign irq_event[`TCMO_IRQ_CAPTURE] = capture_load & s_q.ctrl[`TCMO_BIT_CAP_IRQ]; // [R2]
  assign irq_event[`TCMO_IRQ_MATCH]   = |match_start;
  assign wr_status = WR_I & (ADDR_I == `TCMO_OFF_IRQ_STATUS);
  assign wr_mask   = WR_I & (ADDR_I == `TCMO_OFF_IRQ_MASK);

  tcmo_irq_ctrl #(
    .NEV (`TCMO_NUM_IRQ)
  ) u_irq_ctrl (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .event_i     (irq_event),
    .wr_status_i (wr_status),
    .wr_mask_i   (wr_mask),
    .wdata_i     (WDATA_I[`TCMO_NUM_IRQ-1:0]),
    .status_o    (irq_status),
    .mask_o      (irq_mask),
    .irq_o       (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d       = s_q;
    s_d.hit   = match_eq;
    s_d.rdata = 32'h0000_0000;

    // register writes; the capture value has no write path
    if (WR_I) begin
      unique case (ADDR_I)
        `TCMO_OFF_CAP_CTRL: begin
          s_d.ctrl = WDATA_I[`TCMO_CTRL_W-1:0];
        end
        `TCMO_OFF_OUT_STATE: begin
          s_d.state_bits = WDATA_I[NUM_OUT-1:0];               // [R10]
        end
        default: begin
        end
      endcase
    end

    if (capture_load) begin
      s_d.captured_count = TIMER_COUNT_I;                     // [R3] [R4] [R7]
    end

    // a match action beats a software write to the same bit in the same cycle
    for (int i = 0; i < NUM_OUT; i++) begin
      if (match_start[i]) begin
        s_d.state_bits[i] = action_level[i];                  // [R15]
      end
    end

    // pwm logic owns the pin when selected; otherwise the state bit drives it
    s_d.pin_out    = (PWM_MODE_I & PWM_LEVEL_I) | (~PWM_MODE_I & s_d.state_bits); // [R8] [R9]
    s_d.pin_select = s_d.ctrl[`TCMO_BIT_CAP_EN];             // [R1]

    // read data stands only in the cycle after the strobe
    if (RD_I) begin
      unique case (ADDR_I)
        `TCMO_OFF_CAP_CTRL: begin
          s_d.rdata[`TCMO_CTRL_W-1:0] = s_q.ctrl;
        end
        `TCMO_OFF_CAP_VALUE: begin
          s_d.rdata[COUNT_W-1:0] = s_q.captured_count;        // [R7]
        end
        `TCMO_OFF_OUT_STATE: begin
          s_d.rdata[NUM_OUT-1:0] = s_q.state_bits;            // [R10]
        end
        `TCMO_OFF_IRQ_STATUS: begin
          s_d.rdata[`TCMO_NUM_IRQ-1:0] = irq_status;
        end
        `TCMO_OFF_IRQ_MASK: begin
          s_d.rdata[`TCMO_NUM_IRQ-1:0] = irq_mask;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q.ctrl           <= `TCMO_RST_CAP_CTRL;
      s_q.captured_count <= `TCMO_RST_CAP_VALUE;             // [R7]
      s_q.state_bits     <= {NUM_OUT{`TCMO_RST_OUT_BIT}};    // [R10]
      s_q.hit            <= {NUM_OUT{1'b0}};
      s_q.pin_out        <= {NUM_OUT{`TCMO_RST_OUT_BIT}};
      s_q.pin_select     <= 1'b0;
      s_q.rdata          <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign RDATA_O              = s_q.rdata;
  assign CAPTURE_PIN_SELECT_O = s_q.pin_select;
  assign MATCH_OUTPUT_PIN_O   = s_q.pin_out;
  assign IRQ_O                = irq;

endmodule

// >>> tcmo_props.sv
// port assertions for the capture and match output block
`timescale 1ns/1ps
module tcmo_props #(
  parameter int NUM_OUT = 24,
  parameter int COUNT_W = 16
)(
  // clock, reset, register port
  input wire logic                       CLOCK_I,
  input wire logic                       RST_I,
  input wire logic [7:0]                 ADDR_I,
  input wire logic [31:0]                WDATA_I,
  input wire logic                       WR_I,
  input wire logic                       RD_I,
  input wire logic [31:0]                RDATA_O,
  // timer core and pins
  input wire logic [COUNT_W-1:0]         TIMER_COUNT_I,
  input wire logic [NUM_OUT*COUNT_W-1:0] MATCH_VALUE_I,
  input wire logic [2*NUM_OUT-1:0]       OUTPUT_ACTION_SELECT_I,
  input wire logic [NUM_OUT-1:0]         PWM_MODE_I,
  input wire logic [NUM_OUT-1:0]         PWM_LEVEL_I,
  input wire logic                       CAPTURE_PIN_SELECT_O,
  input wire logic [NUM_OUT-1:0]         MATCH_OUTPUT_PIN_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire logic       eq0 = MATCH_VALUE_I[COUNT_W-1:0] == TIMER_COUNT_I;
  wire logic [1:0] act0 = OUTPUT_ACTION_SELECT_I[1:0];
  wire logic       wst = WR_I && ADDR_I == 8'h88;
  ////////////////////////////////////////
  sequence s_plain;
    !PWM_MODE_I[0] && !$past(PWM_MODE_I[0]);
  endsequence
  // a held match acts once, so only the first equal cycle counts
  sequence s_hit;
    s_plain ##0 (eq0 && !$past(eq0));
  endsequence
  rd_idle_a: assert property (
    !$past(RD_I) |-> RDATA_O == 32'h0) else $error("read data outside read slot");
  cap_upper_a: assert property (
    $past(RD_I) && $past(ADDR_I) == 8'h84 |-> RDATA_O[31:16] == 16'h0)
    else $error("capture upper bits set");
  state_upper_a: assert property (
    $past(RD_I) && $past(ADDR_I) == 8'h88 |-> RDATA_O[31:24] == 8'h0)
    else $error("state upper bits set");
  sel_set_a: assert property (
    WR_I && ADDR_I == 8'h80 |=> CAPTURE_PIN_SELECT_O == $past(WDATA_I[3]))
    else $error("pin select misses enable");
  sel_hold_a: assert property (
    !(WR_I && ADDR_I == 8'h80) |=> $stable(CAPTURE_PIN_SELECT_O))
    else $error("pin select moved");
  hold_out_a: assert property (
    s_plain ##0 (!eq0 && !wst && !$past(wst)) |=> $stable(MATCH_OUTPUT_PIN_O[0]))
    else $error("output moved without cause");
  toggle_out_a: assert property (
    s_hit ##0 act0 == 2'b11 |=> MATCH_OUTPUT_PIN_O[0] != $past(MATCH_OUTPUT_PIN_O[0]))
    else $error("toggle missed");
  high_out_a: assert property (
    s_hit ##0 act0 == 2'b10 |=> MATCH_OUTPUT_PIN_O[0]) else $error("set high missed");
  low_out_a: assert property (
    s_hit ##0 act0 == 2'b01 |=> !MATCH_OUTPUT_PIN_O[0]) else $error("set low missed");
  pwm_out_a: assert property (
    PWM_MODE_I[1] |=> MATCH_OUTPUT_PIN_O[1] == $past(PWM_LEVEL_I[1]))
    else $error("pwm level not passed");
endmodule
bind tcmo_top tcmo_props #(.NUM_OUT(NUM_OUT), .COUNT_W(COUNT_W)) u_props (.*);

// >>> tcmo_pin_model.sv
// source driving the capture input pin
`timescale 1ns/1ps
module tcmo_pin_model (
  // clock
  input  wire logic clk_i,
  // pin
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // caller keeps each level two cycles or more, else the synchroniser may miss it
  task automatic drive(input logic v);
    @(posedge clk_i);
    pin_o <= v;
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the capture and match output block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb;
  import tcmo_pkg::*;
  logic         CLOCK_I = 1'b0;
  logic         RST_I = 1'b1;
  logic [7:0]   ADDR_I = 8'h00;
  logic [31:0]  WDATA_I = 32'h0;
  logic         WR_I = 1'b0;
  logic         RD_I = 1'b0;
  logic [15:0]  TIMER_COUNT_I = 16'h0;
  logic [383:0] MATCH_VALUE_I = '0;
  logic [47:0]  OUTPUT_ACTION_SELECT_I = '0;
  logic [23:0]  PWM_MODE_I = 24'h0;
  logic [23:0]  PWM_LEVEL_I = 24'h0;
  logic [31:0]  RDATA_O;
  logic         CAPTURE_INPUT_PIN_I;
  logic         CAPTURE_PIN_SELECT_O;
  logic         IRQ_O;
  logic [23:0]  MATCH_OUTPUT_PIN_O;
  logic [15:0]  ecap = 16'h0;
  logic [7:0]   offs [6] = '{8'h80, 8'h84, 8'h88, 8'ha0, 8'ha4, 8'hfc};
  tcmo_action_t acts [5] = '{TCMO_ACT_HIGH, TCMO_ACT_NONE, TCMO_ACT_TOGGLE,
                             TCMO_ACT_TOGGLE, TCMO_ACT_LOW};
  logic [4:0]   pexp = 5'h0b;
  int           bad_count = 0;
  int           n_checks = 0;
  int           cyc = 0;
  tcmo_top DUT (.*);
  tcmo_pin_model PM (.clk_i(CLOCK_I), .pin_o(CAPTURE_INPUT_PIN_I));
  always #25 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) TIMER_COUNT_I <= RST_I ? 16'h0 : TIMER_COUNT_I + 16'h1;
  always @(posedge CLOCK_I) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1 `CHK("rdata", e, RDATA_O)
  endtask
  // count seen at the load is two beyond the count after the pin edge
  task automatic cap(input logic v, input logic take, input logic i);
    PM.drive(v);
    #1;
    if (take) ecap = TIMER_COUNT_I + 16'h2;
    repeat (3) @(posedge CLOCK_I);
    rd(8'h84, {16'h0, ecap});
    `CHK("irq", i, IRQ_O)
    if (i) wr(8'ha0, 32'h1);
  endtask
  task automatic hit(input tcmo_action_t a, input logic e);
    @(posedge CLOCK_I);
    OUTPUT_ACTION_SELECT_I[1:0] <= a;
    MATCH_VALUE_I[15:0] <= TIMER_COUNT_I + 16'h3;
    repeat (6) @(posedge CLOCK_I);
    #1 `CHK("pin0", e, MATCH_OUTPUT_PIN_O[0])
    rd(8'h88, {31'h0, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    foreach (offs[i]) rd(offs[i], 32'h0);
    wr(8'h80, 32'hffff_ffff);
    `CHK("sel", 1'b1, CAPTURE_PIN_SELECT_O)
    rd(8'h80, 32'hf);
    wr(8'h84, 32'hffff_ffff);
    rd(8'h84, 32'h0);
    wr(8'h88, 32'hffff_ffff);
    rd(8'h88, 32'h00ff_ffff);
    `CHK("pins", 24'hff_ffff, MATCH_OUTPUT_PIN_O)
    wr(8'h88, 32'h0);
    wr(8'ha4, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(8'h80, 32'hc | m);
      cap(1'b1, m[0], m[0]);
      cap(1'b0, m[1], m[1]);
    end
    wr(8'ha4, 32'h0);
    wr(8'h80, 32'hd);
    cap(1'b1, 1'b1, 1'b0);
    rd(8'ha0, 32'h1);
    wr(8'ha0, 32'h1);
    wr(8'h80, 32'h3);
    cap(1'b0, 1'b0, 1'b0);
    `CHK("sel", 1'b0, CAPTURE_PIN_SELECT_O)
    // counter-mode safe setting: enabled, low three bits zero, so no edge may load
    wr(8'h80, 32'h8);
    `CHK("sel", 1'b1, CAPTURE_PIN_SELECT_O)
    cap(1'b1, 1'b0, 1'b0);
    rd(8'ha0, 32'h0);
    for (int i = 0; i < 5; i++) hit(acts[i], pexp[i]);
    // each non-none match action above raised the match status bit
    rd(8'ha0, 32'h2);
    @(posedge CLOCK_I);
    PWM_MODE_I <= 24'h2;
    PWM_LEVEL_I <= 24'h2;
    repeat (3) @(posedge CLOCK_I);
    #1 `CHK("pwm", 1'b1, MATCH_OUTPUT_PIN_O[1])
    summarize();
  end
endmodule
